/* verilog/rcg_pkg.sv */
// Constants shared by the run-mode clock gating bank and its clock gate cell
package rcg_pkg;
  localparam int unsigned RCG_DATA_W = 32;
  localparam int unsigned RCG_ADDR_W = 12;
  localparam logic [31:0] RCG_SYS_CTRL_BASE = 32'h400fe000;
  // Byte offsets within the system control block
  localparam logic [11:0] RCG_OFS_RUN_GATE = 12'h104;
  localparam logic [11:0] RCG_OFS_SLEEP_GATE = 12'h114;
  localparam logic [11:0] RCG_OFS_DEEP_GATE = 12'h124;
  localparam logic [11:0] RCG_OFS_MODE_CFG = 12'h060;
  localparam logic [11:0] RCG_OFS_IRQ_STATUS = 12'h200;
  localparam logic [11:0] RCG_OFS_IRQ_MASK = 12'h204;
  localparam logic [11:0] RCG_OFS_ACTIVE_GATE = 12'h208;
  // Gating bit positions
  localparam int unsigned RCG_BIT_ASYNC_SERIAL = 0;
  localparam int unsigned RCG_BIT_SYNC_SERIAL = 4;
  localparam int unsigned RCG_BIT_QUAD_DECODER = 8;
  localparam int unsigned RCG_BIT_TWO_WIRE = 12;
  localparam int unsigned RCG_BIT_GP_TMR_0 = 16;
  localparam int unsigned RCG_BIT_GP_TMR_3 = 19;
  localparam int unsigned RCG_BIT_ANALOG_CMP_0 = 24;
  localparam int unsigned RCG_BIT_ANALOG_CMP_2 = 26;
  localparam logic [31:0] RCG_GATE_WMASK = 32'h070f1111;
  localparam logic [31:0] RCG_GATE_RESET = 32'h00000000;
  // Mode configuration register field
  localparam int unsigned RCG_BIT_AUTO_GATE = 0;
  localparam logic [31:0] RCG_MODE_CFG_RESET = 32'h00000000;
  // Interrupt status bits
  localparam int unsigned RCG_IRQ_W = 2;
  localparam int unsigned RCG_IRQ_BIT_FAULT = 0;
  localparam int unsigned RCG_IRQ_BIT_SET_CHANGE = 1;
  localparam logic [RCG_IRQ_W-1:0] RCG_IRQ_RESET = 2'h0;
  // Avalon-MM response codes
  localparam logic [1:0] RCG_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCG_RESP_DECODE_ERR = 2'h3;
  // Cycles from request to waitrequest low
  localparam int unsigned RCG_BUS_LATENCY = 1;
  typedef enum logic [1:0] {
    RCG_SET_RUN,
    RCG_SET_SLEEP,
    RCG_SET_DEEP
  } rcg_set_e;
endpackage

/* verilog/rcg_clk_gate.sv */
// Glitch-free clock gate cell: enable latched while the clock is low
`timescale 1ns/1ps
module rcg_clk_gate
  import rcg_pkg::*;
(
  input wire logic clk_i,
  input wire logic en_i,
  output logic gclk_o
);
  logic en_latch;

  // Enable can only change while clk_i is low, so the AND never chops a high phase
  always_latch begin
    if (!clk_i) begin
      en_latch <= en_i;
    end
  end

  assign gclk_o = clk_i & en_latch;
endmodule

/* verilog/rcg_gate_bank.sv */
// Run, sleep and deep-sleep clock gating bank 1 with Avalon-MM slave and unit fault check
// What this block does
// [RL1] Each writable gating bit drives exactly one unit clock enable, independently.
// [RL2] A set gating bit supplies the unit's clock.
// [RL3] A clear gating bit withholds the unit's clock.
// [RL4] Access to a gated-off unit is answered with a bus fault.
// [RL5] All gating bits reset to zero; whole register resets to zero.
// [RL6] Software must enable each needed unit before use.
// [RL7] Three gating sets: run, sleep and deep sleep, each chosen by mode.
// [RL8] Sleep sets replace run set only when auto gating select is set.
// [RL9] Run gating register sits at offset 0x104, 32 bits wide.
// [RL10] Bits 24 to 26 gate analog comparators 0 to 2, read/write.
// [RL11] Unassigned bits, including 31:27, read zero and ignore writes.
// [RL12] Bits 16 to 19 gate timer units 0 to 3, read/write.
// [RL13] Bit 12 two-wire, bit 8 quadrature decoder, bit 4 synchronous serial.
// [RL14] Bit 0 gates the asynchronous serial unit, read/write.
// [RL15] Gating changes reach unit clocks glitch-free through latch-based gates.
// [RL16] Unit fault raised in the decode cycle; the unit sees no access.
`timescale 1ns/1ps
module rcg_gate_bank
  import rcg_pkg::*;
#(
  parameter int unsigned DATA_W = RCG_DATA_W,
  parameter int unsigned ADDR_W = RCG_ADDR_W
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [DATA_W/8-1:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // Power mode from the processor core, same clock
  input wire logic sleep_i,
  input wire logic deep_sleep_i,
  // Per-unit access selects from the system address decoder, indexed by gating bit
  input wire logic [DATA_W-1:0] unit_sel_i,
  output logic [DATA_W-1:0] unit_sel_o,
  output logic unit_fault_o,
  // Gated unit clocks and the enables behind them
  output logic [DATA_W-1:0] unit_clk_o,
  output logic [DATA_W-1:0] unit_en_o,
  output logic irq_o
);
  logic [DATA_W-1:0] run_clock_gate_bank1_reg;
  logic [DATA_W-1:0] sleep_clock_gate_bank1_reg;
  logic [DATA_W-1:0] deep_sleep_clock_gate_bank1_reg;
  logic [DATA_W-1:0] run_mode_clock_config_reg;
  logic [RCG_IRQ_W-1:0] irq_status_reg;
  logic [RCG_IRQ_W-1:0] irq_status_next;
  logic [RCG_IRQ_W-1:0] irq_mask_reg;
  logic ack_reg;
  logic [DATA_W-1:0] readdata_reg;
  logic [1:0] response_reg;
  rcg_set_e set_sel;
  rcg_set_e set_sel_reg;

  // Merge a write into a register under byte enables and a writable-bit mask
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] wdata,
                                                 input logic [DATA_W/8-1:0] be,
                                                 input logic [DATA_W-1:0] wmask);
    logic [DATA_W-1:0] lane;
    lane = '0;
    for (int i = 0; i < DATA_W/8; i++) begin
      lane[i*8 +: 8] = {8{be[i]}};
    end
    be_merge = (old_v & ~(lane & wmask)) | (wdata & lane & wmask);
  endfunction

  // Bus decode
  wire bus_req = avs_read_i | avs_write_i;
  wire bus_take = bus_req & ack_reg;
  wire bus_wr = avs_write_i & ack_reg;
  wire hit_run = (avs_address_i == RCG_OFS_RUN_GATE); // RL9
  wire hit_sleep = (avs_address_i == RCG_OFS_SLEEP_GATE);
  wire hit_deep = (avs_address_i == RCG_OFS_DEEP_GATE);
  wire hit_cfg = (avs_address_i == RCG_OFS_MODE_CFG);
  wire hit_stat = (avs_address_i == RCG_OFS_IRQ_STATUS);
  wire hit_mask = (avs_address_i == RCG_OFS_IRQ_MASK);
  wire hit_active = (avs_address_i == RCG_OFS_ACTIVE_GATE);
  wire hit_any = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_mask | hit_active;
  wire auto_gate = run_mode_clock_config_reg[RCG_BIT_AUTO_GATE];
  logic [DATA_W-1:0] active_gate;
  logic [DATA_W-1:0] rd_mux;

  // Fixed one-cycle wait state: request seen, waitrequest released next cycle
  assign avs_waitrequest_o = bus_req & ~ack_reg;
  assign avs_readdata_o = readdata_reg;
  assign avs_response_o = response_reg;

  always_comb begin
    if (hit_run) begin
      rd_mux = run_clock_gate_bank1_reg;
    end else if (hit_sleep) begin
      rd_mux = sleep_clock_gate_bank1_reg;
    end else if (hit_deep) begin
      rd_mux = deep_sleep_clock_gate_bank1_reg;
    end else if (hit_cfg) begin
      rd_mux = run_mode_clock_config_reg;
    end else if (hit_stat) begin
      rd_mux = {{(DATA_W-RCG_IRQ_W){1'b0}}, irq_status_reg};
    end else if (hit_mask) begin
      rd_mux = {{(DATA_W-RCG_IRQ_W){1'b0}}, irq_mask_reg};
    end else if (hit_active) begin
      rd_mux = active_gate;
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_reg <= 1'b0;
      readdata_reg <= '0;
      response_reg <= RCG_RESP_OKAY;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg) begin
        readdata_reg <= avs_read_i ? rd_mux : '0;
        response_reg <= hit_any ? RCG_RESP_OKAY : RCG_RESP_DECODE_ERR;
      end
    end
  end

  // Gating registers; reserved bits are held at zero by the writable mask
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_clock_gate_bank1_reg <= RCG_GATE_RESET; // RL5
      sleep_clock_gate_bank1_reg <= RCG_GATE_RESET;
      deep_sleep_clock_gate_bank1_reg <= RCG_GATE_RESET;
      run_mode_clock_config_reg <= RCG_MODE_CFG_RESET;
      irq_mask_reg <= RCG_IRQ_RESET;
    end else if (bus_wr) begin
      if (hit_run) begin
        run_clock_gate_bank1_reg <= be_merge(run_clock_gate_bank1_reg, avs_writedata_i, avs_byteenable_i,
                                             RCG_GATE_WMASK); // RL10 RL11 RL12 RL13 RL14
      end
      if (hit_sleep) begin
        sleep_clock_gate_bank1_reg <= be_merge(sleep_clock_gate_bank1_reg, avs_writedata_i, avs_byteenable_i,
                                               RCG_GATE_WMASK);
      end
      if (hit_deep) begin
        deep_sleep_clock_gate_bank1_reg <= be_merge(deep_sleep_clock_gate_bank1_reg, avs_writedata_i,
                                                    avs_byteenable_i, RCG_GATE_WMASK);
      end
      if (hit_cfg) begin
        run_mode_clock_config_reg <= be_merge(run_mode_clock_config_reg, avs_writedata_i, avs_byteenable_i,
                                              32'h00000001);
      end
      if (hit_mask && avs_byteenable_i[0]) begin
        irq_mask_reg <= avs_writedata_i[RCG_IRQ_W-1:0];
      end
    end
  end

  // Gating set selection: sleep sets only count while auto gating is selected
  always_comb begin
    if (auto_gate && deep_sleep_i) begin
      set_sel = RCG_SET_DEEP; // RL7 RL8
    end else if (auto_gate && sleep_i) begin
      set_sel = RCG_SET_SLEEP; // RL7 RL8
    end else begin
      set_sel = RCG_SET_RUN;
    end
  end

  always_comb begin
    case (set_sel)
      RCG_SET_DEEP: active_gate = deep_sleep_clock_gate_bank1_reg;
      RCG_SET_SLEEP: active_gate = sleep_clock_gate_bank1_reg;
      default: active_gate = run_clock_gate_bank1_reg;
    endcase
  end

  assign unit_en_o = active_gate; // RL1

  // One latch-based gate per writable bit; unassigned bits carry no clock
  for (genvar g = 0; g < DATA_W; g++) begin : g_gate
    if (RCG_GATE_WMASK[g]) begin : g_on
      rcg_clk_gate u_gate (
        .clk_i(mclk_i),
        .en_i(active_gate[g]),
        .gclk_o(unit_clk_o[g])
      ); // RL2 RL3 RL15
    end else begin : g_off
      assign unit_clk_o[g] = 1'b0;
    end
  end

  // Access to an unclocked unit is stopped here and faulted in the same cycle
  wire [DATA_W-1:0] blocked_sel = unit_sel_i & ~active_gate;
  assign unit_fault_o = |blocked_sel; // RL4 RL16
  assign unit_sel_o = unit_sel_i & active_gate; // RL16

  // Sticky status, write one to clear; a new event wins over a clear
  wire stat_clr_en = bus_wr & hit_stat & avs_byteenable_i[0];
  wire [RCG_IRQ_W-1:0] stat_clr = stat_clr_en ? avs_writedata_i[RCG_IRQ_W-1:0] : '0;
  wire [RCG_IRQ_W-1:0] stat_set = {set_sel != set_sel_reg, unit_fault_o};

  always_comb begin
    irq_status_next = (irq_status_reg & ~stat_clr) | stat_set;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status_reg <= RCG_IRQ_RESET;
      set_sel_reg <= RCG_SET_RUN;
    end else begin
      irq_status_reg <= irq_status_next;
      set_sel_reg <= set_sel;
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  a_fault_gated_unit: assert property ((|(unit_sel_i & ~unit_en_o)) |-> unit_fault_o) // RL4
    else $error("access to a gated-off unit did not fault");
  a_fault_only_gated: assert property (unit_fault_o |-> (|(unit_sel_i & ~unit_en_o)))  // RL16
    else $error("fault raised for an enabled unit");
  a_no_pass_gated: assert property ((unit_sel_o & ~unit_en_o) == '0) // RL16
    else $error("access passed to a gated-off unit");
  a_reserved_zero: assert property ((run_clock_gate_bank1_reg & ~RCG_GATE_WMASK) == '0) // RL11
    else $error("reserved gating bit became set");
  a_run_write_lands: assert property (avs_write_i && !avs_waitrequest_o && hit_run &&
                                      (&avs_byteenable_i) |=>
                                      run_clock_gate_bank1_reg == ($past(avs_writedata_i) & RCG_GATE_WMASK)) // RL9
    else $error("run gating write not stored");
  a_run_set_used: assert property (!auto_gate |-> unit_en_o == run_clock_gate_bank1_reg) // RL8
    else $error("sleep set used without auto gating");
  a_deep_set_used: assert property (auto_gate && deep_sleep_i |-> unit_en_o == deep_sleep_clock_gate_bank1_reg) // RL7
    else $error("deep-sleep set not applied");
  a_sleep_set_used: assert property (auto_gate && sleep_i && !deep_sleep_i |->
                                     unit_en_o == sleep_clock_gate_bank1_reg) // RL7
    else $error("sleep set not applied");
  a_wait_one_cycle: assert property ($rose(bus_req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("waitrequest not released after one cycle");
  a_fault_sticky: assert property (unit_fault_o |=> irq_status_reg[RCG_IRQ_BIT_FAULT])
    else $error("fault event lost");

  // Unit clocks are looked at in their high phase; a posedge sample would always see them low
  a_tmr3_clock: assert property (@(negedge mclk_i) !$past(unit_en_o[RCG_BIT_GP_TMR_3]) |-> // RL3 RL12
                                 !unit_clk_o[RCG_BIT_GP_TMR_3])
    else $error("gated timer clock toggled");

  // The enable seen in one high phase holds through the low phase and is latched for the next pulse
  a_unit_clk_follow: assert property (@(negedge mclk_i) // RL2 RL3 RL15
                                      unit_clk_o == ($past(unit_en_o) & RCG_GATE_WMASK))
    else $error("unit clock does not follow its latched enable");

  // Bus answers
  a_resp_unmapped: assert property (bus_take && !hit_any |-> avs_response_o == RCG_RESP_DECODE_ERR)
    else $error("unmapped access not answered with a decode error");

  a_resp_mapped: assert property (bus_take && hit_any |-> avs_response_o == RCG_RESP_OKAY)
    else $error("mapped access not answered as okay");

  a_write_rdata_zero: assert property (bus_take && avs_write_i |-> avs_readdata_o == '0)
    else $error("write answered with nonzero read data");

  a_run_read_back: assert property (bus_take && avs_read_i && hit_run |-> // RL9
                                    avs_readdata_o == run_clock_gate_bank1_reg)
    else $error("run gating read returned stale data");

  a_unmapped_no_write: assert property (bus_wr && !hit_any |=> $stable(run_clock_gate_bank1_reg))
    else $error("unmapped write changed the run gating register");

  // Sleep and deep-sleep sets
  a_sleep_write_lands: assert property (avs_write_i && !avs_waitrequest_o && hit_sleep && (&avs_byteenable_i) |=> // RL7
                                        sleep_clock_gate_bank1_reg == ($past(avs_writedata_i) & RCG_GATE_WMASK))
    else $error("sleep gating write not stored");

  a_deep_write_lands: assert property (avs_write_i && !avs_waitrequest_o && hit_deep && // RL7
                                       (&avs_byteenable_i) |=>
                                       deep_sleep_clock_gate_bank1_reg == ($past(avs_writedata_i) & RCG_GATE_WMASK))
    else $error("deep-sleep gating write not stored");

  a_sleep_reserved_zero: assert property ((sleep_clock_gate_bank1_reg & ~RCG_GATE_WMASK) == '0) // RL11
    else $error("reserved sleep gating bit became set");

  a_deep_reserved_zero: assert property ((deep_sleep_clock_gate_bank1_reg & ~RCG_GATE_WMASK) == '0) // RL11
    else $error("reserved deep-sleep gating bit became set");

  // Interrupt status
  a_stat_clear: assert property (stat_clr_en && avs_writedata_i[RCG_IRQ_BIT_FAULT] && !unit_fault_o |=>
                                 !irq_status_reg[RCG_IRQ_BIT_FAULT])
    else $error("fault status not cleared by a one");

  a_set_change_flag: assert property (set_sel != set_sel_reg |=> irq_status_reg[RCG_IRQ_BIT_SET_CHANGE])
    else $error("gating set change not recorded");

  c_run_enable: cover property (bus_wr && hit_run && avs_writedata_i[RCG_BIT_ANALOG_CMP_2]);
  c_unit_fault: cover property (unit_fault_o);
  c_deep_switch: cover property (auto_gate && $rose(deep_sleep_i));
  c_sleep_switch: cover property (auto_gate && $rose(sleep_i));
  c_irq_raise: cover property ($rose(irq_o));
endmodule

/* dv/tb_top.sv */
// Self-checking testbench for the run-mode clock gating bank
`timescale 1ns/1ps
module tb_top
  import rcg_pkg::*;
;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [11:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic sleep_i = 1'b0;
  logic deep_sleep_i = 1'b0;
  logic [31:0] unit_sel_i = '0;
  logic [31:0] avs_readdata_o, unit_sel_o, unit_clk_o, unit_en_o;
  logic [1:0] avs_response_o;
  logic avs_waitrequest_o, unit_fault_o, irq_o;
  int err_count = 0;
  int num_checks = 0;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'h0000027a;

  rcg_gate_bank dut (.mclk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_response_o, .avs_waitrequest_o, .sleep_i, .deep_sleep_i,
    .unit_sel_i, .unit_sel_o, .unit_fault_o, .unit_clk_o, .unit_en_o, .irq_o);

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check({2'h0, got}, {2'h0, exp});
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Called right after a rising edge; the request stands until the edge that samples waitrequest low
  task automatic bus(input logic is_wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= is_wr;
    avs_read_i <= ~is_wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      check({33'h0, avs_waitrequest_o}, 34'h0);
      complete_run();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    // One idle edge so the next request never rewrites a strobe in this time step
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, {RCG_RESP_OKAY, 32'h0});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    bus(1'b0, a, 32'h0, {RCG_RESP_OKAY, d});
  endtask

  // Answers are taken at the rising edge at which waitrequest is sampled low
  always @(posedge mclk_i) begin
    if (arst_n_i && (avs_read_i || avs_write_i) && avs_waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) begin
        check({avs_response_o, avs_readdata_o}, 34'h3ffffffff);
      end else begin
        check({avs_response_o, avs_readdata_o}, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    check(34'h1, 34'h0);
    complete_run();
  end

  initial begin
    logic [31:0] v, s;
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(RCG_OFS_RUN_GATE, RCG_GATE_RESET);
    rd(RCG_OFS_MODE_CFG, RCG_MODE_CFG_RESET);
    chk(unit_en_o, 32'h0);
    $display("reset test done");
    wr(RCG_OFS_RUN_GATE, 32'hffffffff);
    rd(RCG_OFS_RUN_GATE, RCG_GATE_WMASK);
    @(posedge mclk_i);
    #1 chk(unit_clk_o, RCG_GATE_WMASK);
    @(negedge mclk_i);
    #1 chk(unit_clk_o, 32'h0);
    @(posedge mclk_i);
    wr(RCG_OFS_RUN_GATE, 32'h0);
    @(posedge mclk_i);
    #1 chk(unit_clk_o, 32'h0);
    $display("field test done");
    @(posedge mclk_i);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = seed;
      wr(RCG_OFS_RUN_GATE, v);
      rd(RCG_OFS_RUN_GATE, v & RCG_GATE_WMASK);
      seed = lfsr(seed);
      s = seed & RCG_GATE_WMASK;
      unit_sel_i <= s;
      @(negedge mclk_i);
      chk(unit_en_o, v & RCG_GATE_WMASK);
      chk(unit_sel_o, s & v);
      chk({31'h0, unit_fault_o}, {31'h0, |(s & ~v)});
      @(posedge mclk_i);
      unit_sel_i <= '0;
    end
    $display("random test done");
    bus(1'b0, 12'h300, 32'h0, {RCG_RESP_DECODE_ERR, 32'h0});
    wr(RCG_OFS_RUN_GATE, 32'h0);
    bus(1'b1, 12'h3fc, 32'hffffffff, {RCG_RESP_DECODE_ERR, 32'h0});
    rd(RCG_OFS_RUN_GATE, 32'h0);
    wr(RCG_OFS_IRQ_STATUS, 32'h3);
    unit_sel_i <= 32'h00010000;
    @(negedge mclk_i);
    chk({31'h0, unit_fault_o}, 32'h1);
    @(posedge mclk_i);
    unit_sel_i <= '0;
    rd(RCG_OFS_IRQ_STATUS, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    wr(RCG_OFS_IRQ_MASK, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    wr(RCG_OFS_IRQ_STATUS, 32'h1);
    rd(RCG_OFS_IRQ_STATUS, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    $display("fault and interrupt test done");
    wr(RCG_OFS_SLEEP_GATE, 32'h00010001);
    wr(RCG_OFS_DEEP_GATE, 32'h04000010);
    wr(RCG_OFS_RUN_GATE, 32'h00001100);
    sleep_i <= 1'b1;
    @(negedge mclk_i);
    chk(unit_en_o, 32'h00001100);
    @(posedge mclk_i);
    wr(RCG_OFS_MODE_CFG, 32'h1);
    chk(unit_en_o, 32'h00010001);
    deep_sleep_i <= 1'b1;
    @(negedge mclk_i);
    chk(unit_en_o, 32'h04000010);
    @(posedge mclk_i);
    rd(RCG_OFS_ACTIVE_GATE, 32'h04000010);
    sleep_i <= 1'b0;
    deep_sleep_i <= 1'b0;
    @(negedge mclk_i);
    chk(unit_en_o, 32'h00001100);
    @(posedge mclk_i);
    // Set changes were recorded as events; the fault bit stays clear
    rd(RCG_OFS_IRQ_STATUS, 32'h2);
    chk({31'h0, irq_o}, 32'h0);
    $display("mode test done");
    complete_run();
  end
endmodule
